/* quad_cfg_pkg.sv */
// Constants for the analog quad configuration byte decoder
package quad_cfg_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Byte indices on the analog configuration port
  localparam logic [1:0] VOLTAGE_IDX = 2'h0;
  localparam logic [1:0] CURRENT_IDX = 2'h1;
  localparam logic [1:0] GATE_IDX = 2'h2;
  localparam logic [1:0] THERMAL_IDX = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values: largest range, prescaler path, switches off, power-down
  localparam logic [7:0] VOLTAGE_RST = 8'h00;
  localparam logic [7:0] CURRENT_RST = 8'h00;
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [7:0] THERMAL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Sense pad byte fields
  localparam int RANGE_LSB = 0;
  localparam int RANGE_MSB = 2;
  localparam int MUX_LSB = 3;
  localparam int MUX_MSB = 4;
  localparam int DIRECT_BIT = 5;
  localparam int POLARITY_BIT = 6;
  localparam int OPAMP_BIT = 7;
  localparam int MONITOR_SWITCH_BIT = 4;

  // Gate drive byte fields
  localparam int TEMP_MON_BIT = 0;
  localparam int GATE_CUR_LSB = 2;
  localparam int GATE_CUR_MSB = 3;
  localparam int GATE_POL_BIT = 6;
  localparam int GATE_HIGH_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Converter source select codes
  typedef enum logic [1:0] {
    MUX_PRESCALER = 2'b00,
    MUX_DIRECT = 2'b01,
    MUX_MONITOR = 2'b10,
    MUX_INVALID = 2'b11
  } mux_sel_e;

  // Low-drive gate current codes
  typedef enum logic [1:0] {
    GATE_1UA = 2'b00,
    GATE_3UA = 2'b01,
    GATE_10UA = 2'b10,
    GATE_30UA = 2'b11
  } gate_current_e;

  // Largest and smallest prescaler ranges
  localparam logic [2:0] RANGE_LARGEST = 3'b000;
  localparam logic [2:0] RANGE_SMALLEST = 3'b111;
  // Only ranges usable by the temperature monitor prescaler
  localparam logic [2:0] THERMAL_RANGE_A = 3'b000;
  localparam logic [2:0] THERMAL_RANGE_B = 3'b010;

endpackage

/* sense_pad_decode.sv */
// Registered field decoder for one voltage, current or temperature sense pad
module sense_pad_decode
  import quad_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] cfg_byte,
  output logic [2:0] range_sel,
  output logic src_prescaler,
  output logic src_direct,
  output logic src_monitor,
  output logic src_invalid,
  output logic direct_switch,
  output logic polarity_neg,
  output logic opamp_on
);

  mux_sel_e mux_code;

  assign mux_code = mux_sel_e'(cfg_byte[MUX_MSB:MUX_LSB]);

  ////////////////////////////////////////////////////////////////////////////
  // Converter source, one-hot once out of reset (all low in reset); code 11 leaves every switch open
  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_prescaler <= 1'b0;
      src_direct <= 1'b0;
      src_monitor <= 1'b0;
      src_invalid <= 1'b0;
    end else begin
      src_prescaler <= (mux_code == MUX_PRESCALER);
      src_direct <= (mux_code == MUX_DIRECT);
      src_monitor <= (mux_code == MUX_MONITOR);
      src_invalid <= (mux_code == MUX_INVALID);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog front end controls
  always_ff @(posedge clk) begin
    if (!resetn) begin
      range_sel <= RANGE_LARGEST;
      direct_switch <= 1'b0;
      polarity_neg <= 1'b0;
      opamp_on <= 1'b0;
    end else begin
      range_sel <= cfg_byte[RANGE_MSB:RANGE_LSB];
      direct_switch <= cfg_byte[DIRECT_BIT];
      polarity_neg <= cfg_byte[POLARITY_BIT];
      opamp_on <= cfg_byte[OPAMP_BIT];
    end
  end

endmodule

/* analog_quad_config_decode.sv */
// Analog quad configuration bytes and their decode into analog control lines
module analog_quad_config_decode
  import quad_cfg_pkg::*;
#(
  parameter int CFG_BYTE_W = 8
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_wen,
  input wire logic [1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_wack,
  input wire logic gate_driver_on,
  output logic [2:0] voltage_sense_pad_range,
  output logic voltage_sense_pad_src_prescaler,
  output logic voltage_sense_pad_src_direct,
  output logic voltage_sense_pad_src_monitor,
  output logic voltage_sense_pad_src_invalid,
  output logic voltage_sense_pad_direct_switch,
  output logic voltage_sense_pad_polarity_neg,
  output logic voltage_sense_pad_opamp_on,
  output logic voltage_sense_pad_monitor_switch,
  output logic [2:0] current_sense_pad_range,
  output logic current_sense_pad_src_prescaler,
  output logic current_sense_pad_src_direct,
  output logic current_sense_pad_src_monitor,
  output logic current_sense_pad_src_invalid,
  output logic current_sense_pad_direct_switch,
  output logic current_sense_pad_polarity_neg,
  output logic current_sense_pad_opamp_on,
  output logic [2:0] thermal_sense_pad_range,
  output logic thermal_sense_pad_src_prescaler,
  output logic thermal_sense_pad_src_direct,
  output logic thermal_sense_pad_src_monitor,
  output logic thermal_sense_pad_src_invalid,
  output logic thermal_sense_pad_direct_switch,
  output logic thermal_sense_pad_polarity_neg,
  output logic thermal_sense_pad_opamp_on,
  output logic [1:0] gate_drive_pad_current_sel,
  output logic gate_drive_pad_polarity_neg,
  output logic gate_drive_pad_low_on,
  output logic gate_drive_pad_high_on,
  output logic chip_temp_monitor_enable,
  output logic thermal_cfg_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Only byte-wide bytes are decoded
  if (CFG_BYTE_W != BYTE_W) begin : g_width_check
    $error("CFG_BYTE_W must be 8");
  end

  logic [7:0] voltage_pad_config_r;
  logic [7:0] current_pad_config_r;
  logic [7:0] gate_drive_pad_config_r;
  logic [7:0] temperature_pad_config_r;
  logic [7:0] rdata_nxt;
  logic thermal_bad_range;
  gate_current_e gate_current_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration byte store
  always_ff @(posedge clk) begin
    if (!resetn) begin
      voltage_pad_config_r <= VOLTAGE_RST;
      current_pad_config_r <= CURRENT_RST;
      gate_drive_pad_config_r <= GATE_RST;
      temperature_pad_config_r <= THERMAL_RST;
    end else if (cfg_wen) begin
      case (cfg_addr)
        VOLTAGE_IDX: begin
          voltage_pad_config_r <= cfg_wdata;
        end
        CURRENT_IDX: begin
          current_pad_config_r <= cfg_wdata;
        end
        GATE_IDX: begin
          gate_drive_pad_config_r <= cfg_wdata;
        end
        THERMAL_IDX: begin
          temperature_pad_config_r <= cfg_wdata;
        end
        default: begin
          voltage_pad_config_r <= voltage_pad_config_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back of the addressed byte, spare bits returned as written
  always_comb begin
    case (cfg_addr)
      VOLTAGE_IDX: rdata_nxt = voltage_pad_config_r;
      CURRENT_IDX: rdata_nxt = current_pad_config_r;
      GATE_IDX: rdata_nxt = gate_drive_pad_config_r;
      THERMAL_IDX: rdata_nxt = temperature_pad_config_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_rdata <= 8'h00;
      cfg_wack <= 1'b0;
    end else begin
      cfg_rdata <= rdata_nxt;
      cfg_wack <= cfg_wen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense pad decoders
  sense_pad_decode u_voltage (
    .clk(clk),
    .resetn(resetn),
    .cfg_byte(voltage_pad_config_r),
    .range_sel(voltage_sense_pad_range),
    .src_prescaler(voltage_sense_pad_src_prescaler),
    .src_direct(voltage_sense_pad_src_direct),
    .src_monitor(voltage_sense_pad_src_monitor),
    .src_invalid(voltage_sense_pad_src_invalid),
    .direct_switch(voltage_sense_pad_direct_switch),
    .polarity_neg(voltage_sense_pad_polarity_neg),
    .opamp_on(voltage_sense_pad_opamp_on)
  );

  sense_pad_decode u_current (
    .clk(clk),
    .resetn(resetn),
    .cfg_byte(current_pad_config_r),
    .range_sel(current_sense_pad_range),
    .src_prescaler(current_sense_pad_src_prescaler),
    .src_direct(current_sense_pad_src_direct),
    .src_monitor(current_sense_pad_src_monitor),
    .src_invalid(current_sense_pad_src_invalid),
    .direct_switch(current_sense_pad_direct_switch),
    .polarity_neg(current_sense_pad_polarity_neg),
    .opamp_on(current_sense_pad_opamp_on)
  );

  // Polarity is passed through; a negative setting is flagged, not masked
  sense_pad_decode u_thermal (
    .clk(clk),
    .resetn(resetn),
    .cfg_byte(temperature_pad_config_r),
    .range_sel(thermal_sense_pad_range),
    .src_prescaler(thermal_sense_pad_src_prescaler),
    .src_direct(thermal_sense_pad_src_direct),
    .src_monitor(thermal_sense_pad_src_monitor),
    .src_invalid(thermal_sense_pad_src_invalid),
    .direct_switch(thermal_sense_pad_direct_switch),
    .polarity_neg(thermal_sense_pad_polarity_neg),
    .opamp_on(thermal_sense_pad_opamp_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Current monitor input switch shares bit 4 with the source field
  always_ff @(posedge clk) begin
    if (!resetn) begin
      voltage_sense_pad_monitor_switch <= 1'b0;
    end else begin
      voltage_sense_pad_monitor_switch <= voltage_pad_config_r[MONITOR_SWITCH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate driver
  assign gate_current_nxt = gate_current_e'(gate_drive_pad_config_r[GATE_CUR_MSB:GATE_CUR_LSB]);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gate_drive_pad_current_sel <= GATE_1UA;
      gate_drive_pad_polarity_neg <= 1'b0;
    end else begin
      gate_drive_pad_current_sel <= gate_current_nxt;
      gate_drive_pad_polarity_neg <= gate_drive_pad_config_r[GATE_POL_BIT];
    end
  end

  // gate_driver_on is a level, sampled each edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gate_drive_pad_low_on <= 1'b0;
      gate_drive_pad_high_on <= 1'b0;
    end else begin
      gate_drive_pad_low_on <= gate_driver_on & ~gate_drive_pad_config_r[GATE_HIGH_BIT];
      gate_drive_pad_high_on <= gate_driver_on & gate_drive_pad_config_r[GATE_HIGH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature monitor enable for this quad only; the chip needs all quads
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chip_temp_monitor_enable <= 1'b0;
    end else begin
      chip_temp_monitor_enable <= gate_drive_pad_config_r[TEMP_MON_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag settings software must avoid on the temperature pad
  assign thermal_bad_range =
    (temperature_pad_config_r[RANGE_MSB:RANGE_LSB] != THERMAL_RANGE_A) &&
    (temperature_pad_config_r[RANGE_MSB:RANGE_LSB] != THERMAL_RANGE_B);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      thermal_cfg_error <= 1'b0;
    end else begin
      thermal_cfg_error <= temperature_pad_config_r[POLARITY_BIT] |
        ((temperature_pad_config_r[MUX_MSB:MUX_LSB] == MUX_MONITOR) &&
         thermal_bad_range);
    end
  end

endmodule

/* quad_cfg_sva.sv */
// Port-level assertions for the analog quad configuration decoder
module quad_cfg_sva
  import quad_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_wen,
  input wire logic [1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wack,
  input wire logic gate_driver_on,
  input wire logic [2:0] voltage_sense_pad_range,
  input wire logic voltage_sense_pad_src_prescaler,
  input wire logic voltage_sense_pad_src_direct,
  input wire logic voltage_sense_pad_src_monitor,
  input wire logic voltage_sense_pad_src_invalid,
  input wire logic voltage_sense_pad_direct_switch,
  input wire logic voltage_sense_pad_polarity_neg,
  input wire logic voltage_sense_pad_opamp_on,
  input wire logic voltage_sense_pad_monitor_switch,
  input wire logic [1:0] gate_drive_pad_current_sel,
  input wire logic gate_drive_pad_polarity_neg,
  input wire logic gate_drive_pad_low_on,
  input wire logic gate_drive_pad_high_on,
  input wire logic chip_temp_monitor_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wv;
  logic wg;
  logic [7:0] wd1;
  logic [7:0] wd2;
  assign wv = cfg_wen && cfg_addr == VOLTAGE_IDX;
  assign wg = cfg_wen && cfg_addr == GATE_IDX;
  // Write data aged to line up with the decoded outputs
  always_ff @(posedge clk) begin
    wd1 <= cfg_wdata;
    wd2 <= wd1;
  end
  wack_pulse_a: assert property (
    $past(resetn) |-> cfg_wack == $past(cfg_wen)) else $error("write ack mismatch");
  temp_mon_a: assert property (
    wg |-> ##2 chip_temp_monitor_enable == wd2[TEMP_MON_BIT]) else $error("tmon mismatch");
  gate_cur_a: assert property (
    wg |-> ##2 gate_drive_pad_current_sel == wd2[3:2]) else $error("gate current mismatch");
  gate_pol_a: assert property (
    wg |-> ##2 gate_drive_pad_polarity_neg == wd2[6]) else $error("gate polarity mismatch");
  drive_off_a: assert property (
    !$past(gate_driver_on) |-> !gate_drive_pad_low_on && !gate_drive_pad_high_on)
    else $error("gate driver on while disabled");
  drive_sel_a: assert property (
    wg ##1 (gate_driver_on && !cfg_wen) ##1 gate_driver_on |=>
    {gate_drive_pad_high_on, gate_drive_pad_low_on} == {$past(wd2[7]), !$past(wd2[7])})
    else $error("gate drive level mismatch");
  src_onehot_a: assert property (
    $past(resetn, 2) && $past(resetn) |-> $onehot({voltage_sense_pad_src_prescaler,
    voltage_sense_pad_src_direct, voltage_sense_pad_src_monitor,
    voltage_sense_pad_src_invalid})) else $error("source select not one-hot");
  volt_src_a: assert property (
    wv |-> ##2 {voltage_sense_pad_src_direct, voltage_sense_pad_src_invalid} ==
    {wd2[4:3] == MUX_DIRECT, wd2[4:3] == MUX_INVALID}) else $error("source mismatch");
  volt_fields_a: assert property (
    wv |-> ##2 {voltage_sense_pad_opamp_on, voltage_sense_pad_polarity_neg,
    voltage_sense_pad_direct_switch, voltage_sense_pad_monitor_switch,
    voltage_sense_pad_range} == {wd2[7:4], wd2[2:0]}) else $error("voltage pad mismatch");
  cover property (wg ##2 chip_temp_monitor_enable);
  cover property (voltage_sense_pad_src_invalid);
  cover property (gate_drive_pad_high_on);
endmodule

bind analog_quad_config_decode quad_cfg_sva chk (
  .clk, .resetn, .cfg_wen, .cfg_addr, .cfg_wdata, .cfg_wack, .gate_driver_on,
  .voltage_sense_pad_range, .voltage_sense_pad_src_prescaler, .voltage_sense_pad_src_direct,
  .voltage_sense_pad_src_monitor, .voltage_sense_pad_src_invalid,
  .voltage_sense_pad_direct_switch, .voltage_sense_pad_polarity_neg,
  .voltage_sense_pad_opamp_on, .voltage_sense_pad_monitor_switch,
  .gate_drive_pad_current_sel, .gate_drive_pad_polarity_neg, .gate_drive_pad_low_on,
  .gate_drive_pad_high_on, .chip_temp_monitor_enable
);

/* gate_load_model.sv */
// Behavioural gate driver load reporting the current it sees
module gate_load_model
  import quad_cfg_pkg::*;
(
  input wire logic [1:0] current_sel,
  input wire logic low_on,
  input wire logic high_on,
  output logic [7:0] load_ua
);
  // High drive lies outside the low table, so it reads as all ones
  always_comb begin
    load_ua = 8'h00;
    if (high_on) begin
      load_ua = 8'hff;
    end else if (low_on) begin
      case (current_sel)
        GATE_1UA: load_ua = 8'h01;
        GATE_3UA: load_ua = 8'h03;
        GATE_10UA: load_ua = 8'h0a;
        default: load_ua = 8'h1e;
      endcase
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the analog quad configuration decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import quad_cfg_pkg::*;
  logic clk;
  logic resetn = 1'b0;
  logic cfg_wen = 1'b0;
  logic gate_driver_on = 1'b0;
  logic [1:0] cfg_addr = 2'h0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic cfg_wack;
  logic msw;
  logic tmon;
  logic [1:0] gsel;
  logic gpol;
  logic glo;
  logic ghi;
  logic terr;
  logic [7:0] load_ua;
  wire [2:0][9:0] pv;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] ua_tab [4] = '{8'h01, 8'h03, 8'h0a, 8'h1e};

  analog_quad_config_decode dut (
    .clk, .resetn, .cfg_wen, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_wack, .gate_driver_on,
    .voltage_sense_pad_range(pv[0][9:7]), .voltage_sense_pad_src_prescaler(pv[0][6]),
    .voltage_sense_pad_src_direct(pv[0][5]), .voltage_sense_pad_src_monitor(pv[0][4]),
    .voltage_sense_pad_src_invalid(pv[0][3]), .voltage_sense_pad_direct_switch(pv[0][2]),
    .voltage_sense_pad_polarity_neg(pv[0][1]), .voltage_sense_pad_opamp_on(pv[0][0]),
    .voltage_sense_pad_monitor_switch(msw),
    .current_sense_pad_range(pv[1][9:7]), .current_sense_pad_src_prescaler(pv[1][6]),
    .current_sense_pad_src_direct(pv[1][5]), .current_sense_pad_src_monitor(pv[1][4]),
    .current_sense_pad_src_invalid(pv[1][3]), .current_sense_pad_direct_switch(pv[1][2]),
    .current_sense_pad_polarity_neg(pv[1][1]), .current_sense_pad_opamp_on(pv[1][0]),
    .thermal_sense_pad_range(pv[2][9:7]), .thermal_sense_pad_src_prescaler(pv[2][6]),
    .thermal_sense_pad_src_direct(pv[2][5]), .thermal_sense_pad_src_monitor(pv[2][4]),
    .thermal_sense_pad_src_invalid(pv[2][3]), .thermal_sense_pad_direct_switch(pv[2][2]),
    .thermal_sense_pad_polarity_neg(pv[2][1]), .thermal_sense_pad_opamp_on(pv[2][0]),
    .gate_drive_pad_current_sel(gsel), .gate_drive_pad_polarity_neg(gpol),
    .gate_drive_pad_low_on(glo), .gate_drive_pad_high_on(ghi),
    .chip_temp_monitor_enable(tmon), .thermal_cfg_error(terr)
  );
  gate_load_model gate_load (.current_sel(gsel), .low_on(glo), .high_on(ghi), .load_ua);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] exp_pad(logic [7:0] b);
    return {b[2:0], b[4:3] == 2'h0, b[4:3] == 2'h1, b[4:3] == 2'h2, b[4:3] == 2'h3,
      b[5], b[6], b[7]};
  endfunction
  task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    cfg_wen <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wen <= 1'b0;
    #1 check("write ack", cfg_wack, 1'b1);
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] e);
    @(posedge clk);
    cfg_addr <= a;
    @(posedge clk);
    #1 check("read data", cfg_rdata, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run is under two hundred cycles
  initial begin
    #50us;
    miscompares++;
    wrap_up();
  end
  initial begin
    logic [7:0] b;
    logic [1:0] pa;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    for (int k = 0; k < 3; k++) check("pad reset", pv[k], exp_pad(8'h00));
    check("tmon reset", tmon, 1'b0);
    $display("reset defaults done");
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 4; m++) begin
        pa = k == 2 ? THERMAL_IDX : k[1:0];
        // Thermal pad stays positive; with the monitor source (m of 2) it uses the largest range, legal for the monitor
        b = {m[0], m[1] && k < 2, ~m[0], m[1:0], m[0] ? RANGE_SMALLEST : RANGE_LARGEST};
        wr(pa, b);
        rd(pa, b);
        check("pad decode", pv[k], exp_pad(b));
        if (k == 0) check("monitor switch", msw, b[4]);
        if (k == 2) check("thermal flag", terr, 1'b0);
      end
    end
    $display("sense pad decode done");
    // Two deliberate misconfigurations so the flag has something to catch, then a legal monitor range
    for (int j = 0; j < 3; j++) begin
      b = j == 0 ? 8'h11 : j == 1 ? 8'h40 : 8'h12;
      wr(THERMAL_IDX, b);
      rd(THERMAL_IDX, b);
      check("thermal flag", terr, j < 2);
    end
    $display("thermal misconfiguration flag done");
    for (int i = 0; i < 16; i++) begin
      b = {i[2], i[1], 2'b00, i[1:0], 1'b0, i[0]};
      @(posedge clk);
      gate_driver_on <= i[3];
      wr(GATE_IDX, b);
      rd(GATE_IDX, b);
      check("load current", load_ua, !i[3] ? 8'h00 : i[2] ? 8'hff : ua_tab[i[1:0]]);
      check("gate fields", {gpol, tmon, gsel}, {b[6], b[0], b[3:2]});
    end
    $display("gate drive decode done");
    wr(GATE_IDX, 8'h81);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(GATE_IDX, 8'h00);
    check("tmon after reset", tmon, 1'b0);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
